/* File: rtl/timebase_gating_ctrl.sv */
// Timebase selection, measurement gating and sequential interval store.
// Assumes an APB master on mclk; inputs are synchronous to mclk.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module timebase_gating_ctrl #(
  parameter int WIN_CYC = tia_cfg_pkg::LOCK_WIN_CYC,
  parameter int SEQ_DEPTH = 64,
  parameter int INH_DEPTH = 16,
  parameter int TICK_W = 29,
  parameter int VAL_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic inhibitIn,
  input wire logic extRefTick,
  input wire logic bpRefTick,
  input wire logic measStrobe,
  input wire logic [TICK_W-1:0] measTicks,
  output logic acqBlocked,
  output logic refLocked
);
  localparam int SA = $clog2(SEQ_DEPTH);
  localparam int IA = $clog2(INH_DEPTH);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic inhEn_q, senseHigh_q, blockPrev_q;
  tia_cfg_pkg::ref_src_t src_q;
  logic [3:0] resExp_q;
  logic [7:0] index_q;
  logic [SA:0] mCnt_q;
  logic [IA:0] iCnt_q;
  logic [VAL_W-1:0] seqMem [SEQ_DEPTH];
  logic [SA:0] inhMem [INH_DEPTH];

  logic acc, rdPh, wr, mapped, badRes, clr;
  logic inhRaw, blocking, accept, inhEvent;
  logic [TICK_W-1:0] shifted;
  logic [VAL_W-1:0] quant;
  logic [31:0] rangeNs, rdVal;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // ----------------------------------------
  // APB slave: one wait state on every access
  // ----------------------------------------
  assign rdPh = psel && penable && !pready;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign mapped = hit(paddr, tia_cfg_pkg::OFF_CTRL) || hit(paddr, tia_cfg_pkg::OFF_RES) ||
    hit(paddr, tia_cfg_pkg::OFF_RANGE) || hit(paddr, tia_cfg_pkg::OFF_STAT) ||
    hit(paddr, tia_cfg_pkg::OFF_MCNT) || hit(paddr, tia_cfg_pkg::OFF_ICNT) ||
    hit(paddr, tia_cfg_pkg::OFF_INDEX) || hit(paddr, tia_cfg_pkg::OFF_SEQ) ||
    hit(paddr, tia_cfg_pkg::OFF_INH) || hit(paddr, tia_cfg_pkg::OFF_ACQ);
  // Out-of-range resolution is refused rather than clipped
  assign badRes = pwrite && hit(paddr, tia_cfg_pkg::OFF_RES) &&
    (pwdata > {28'h000_0000, tia_cfg_pkg::RES_MAX}); // see [R10]
  assign clr = wr && hit(paddr, tia_cfg_pkg::OFF_ACQ) && pwdata[tia_cfg_pkg::ACQ_CLR_BIT];

  // Handshake and error answer
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rdPh;
      pslverr <= rdPh && (!mapped || badRes);
    end
  end

  // Control register writes
  always_ff @(posedge mclk) begin
    if (rst) begin
      inhEn_q <= tia_cfg_pkg::EN_RST; // see [R2]
      senseHigh_q <= tia_cfg_pkg::SENSE_RST; // see [R4]
      src_q <= tia_cfg_pkg::SRC_RST; // see [R6]
    end else if (wr && hit(paddr, tia_cfg_pkg::OFF_CTRL)) begin
      inhEn_q <= pwdata[tia_cfg_pkg::CTRL_EN_BIT];
      senseHigh_q <= pwdata[tia_cfg_pkg::CTRL_SENSE_BIT];
      // Code 3 names no source, so the old one stays
      if (pwdata[tia_cfg_pkg::CTRL_SRC_LSB+:2] != 2'h3) begin
        src_q <= tia_cfg_pkg::ref_src_t'(pwdata[tia_cfg_pkg::CTRL_SRC_LSB+:2]); // see [R5]
      end
    end
  end

  // Resolution exponent: step = finest << exponent
  always_ff @(posedge mclk) begin
    if (rst) resExp_q <= tia_cfg_pkg::RES_RST; // see [R11]
    else if (wr && hit(paddr, tia_cfg_pkg::OFF_RES) && !badRes) begin
      resExp_q <= pwdata[3:0]; // see [R10]
    end
  end

  // Readback index into the data lists
  always_ff @(posedge mclk) begin
    if (rst) index_q <= 8'h00;
    else if (wr && hit(paddr, tia_cfg_pkg::OFF_INDEX)) index_q <= pwdata[7:0];
  end

  // Range doubles with each resolution step
  assign rangeNs = tia_cfg_pkg::RANGE_BASE_NS << resExp_q; // see [R12]

  // Read mux; list entries past the fill level read zero
  always_comb begin
    rdVal = 32'h0000_0000;
    unique case (1'b1)
      hit(paddr, tia_cfg_pkg::OFF_CTRL): rdVal = {28'h000_0000, src_q, senseHigh_q, inhEn_q};
      hit(paddr, tia_cfg_pkg::OFF_RES): rdVal = {28'h000_0000, resExp_q};
      hit(paddr, tia_cfg_pkg::OFF_RANGE): rdVal = rangeNs;
      hit(paddr, tia_cfg_pkg::OFF_STAT): rdVal = {28'h000_0000, src_q, blocking, refLocked};
      hit(paddr, tia_cfg_pkg::OFF_MCNT): rdVal = 32'(mCnt_q);
      hit(paddr, tia_cfg_pkg::OFF_ICNT): rdVal = 32'(iCnt_q);
      hit(paddr, tia_cfg_pkg::OFF_INDEX): rdVal = {24'h00_0000, index_q};
      hit(paddr, tia_cfg_pkg::OFF_SEQ):
        if (9'(index_q) < 9'(mCnt_q)) rdVal = 32'(seqMem[index_q[SA-1:0]]);
      hit(paddr, tia_cfg_pkg::OFF_INH):
        if (9'(index_q) < 9'(iCnt_q)) rdVal = 32'(inhMem[index_q[IA-1:0]]); // see [R3]
      default: rdVal = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) prdata <= 32'h0000_0000;
    else if (rdPh && !pwrite) prdata <= rdVal;
  end

  // ----------------------------------------
  // Gating and timebase
  // ----------------------------------------
  assign inhRaw = senseHigh_q ? inhibitIn : !inhibitIn; // see [R4]
  assign blocking = inhEn_q && inhRaw; // see [R1]
  // No capture without a locked timebase, since step sizes depend on it
  assign accept = measStrobe && !blocking && refLocked &&
    (mCnt_q != (SA+1)'(SEQ_DEPTH)); // see [R1] see [R6] see [R9]
  assign inhEvent = blocking && !blockPrev_q;

  ref_lock_monitor #(.WIN_CYC(WIN_CYC)) lockMon (
    .mclk(mclk),
    .rst(rst),
    .refSrc(src_q),
    .extTick(extRefTick),
    .bpTick(bpRefTick),
    .locked(refLocked)
  );

  // Block status output and edge memory
  always_ff @(posedge mclk) begin
    if (rst) begin
      acqBlocked <= 1'b0;
      blockPrev_q <= 1'b0;
    end else begin
      acqBlocked <= blocking || !refLocked;
      blockPrev_q <= blocking;
    end
  end

  // Quantise to the current step, saturating at the top of the range
  assign shifted = measTicks >> resExp_q;
  assign quant = (|shifted[TICK_W-1:VAL_W]) ? {VAL_W{1'b1}} : shifted[VAL_W-1:0]; // see [R12]

  // Sequential store keeps arrival order
  always_ff @(posedge mclk) begin
    if (rst || clr) mCnt_q <= '0;
    else if (accept) mCnt_q <= mCnt_q + (SA+1)'(1); // see [R13]
  end

  always_ff @(posedge mclk) begin
    if (accept) seqMem[mCnt_q[SA-1:0]] <= quant; // see [R13]
  end

  // Each inhibit activation, up to INH_DEPTH per clear, logs the data position it fell at
  always_ff @(posedge mclk) begin
    if (rst || clr) iCnt_q <= '0;
    else if (inhEvent && iCnt_q != (IA+1)'(INH_DEPTH)) iCnt_q <= iCnt_q + (IA+1)'(1); // see [R3]
  end

  always_ff @(posedge mclk) begin
    if (inhEvent && iCnt_q != (IA+1)'(INH_DEPTH)) inhMem[iCnt_q[IA-1:0]] <= mCnt_q; // see [R3]
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_INH_GATE: assert property ( // see [R1]
    measStrobe && blocking && !clr |=> mCnt_q == $past(mCnt_q))
    else $error("measurement taken while inhibited");
  AST_INH_RST: assert property ($past(rst) |-> !inhEn_q) // see [R2]
    else $error("inhibit enable not off after reset");
  AST_INH_LOG: assert property (inhEvent && !clr && iCnt_q < (IA+1)'(INH_DEPTH) // see [R3]
    |=> iCnt_q == $past(iCnt_q) + (IA+1)'(1) && inhMem[$past(iCnt_q[IA-1:0])] == $past(mCnt_q))
    else $error("inhibit activation not logged");
  AST_SENSE_RST: assert property ($past(rst) |-> !senseHigh_q) // see [R4]
    else $error("sense not low after reset");
  AST_SRC_RST: assert property ( // see [R6]
    $past(rst) |-> src_q == tia_cfg_pkg::SRC_INT && refLocked)
    else $error("source not internal after reset");
  AST_RES_LIMIT: assert property (resExp_q <= tia_cfg_pkg::RES_MAX) // see [R10]
    else $error("resolution out of range");
  AST_RES_RST: assert property ($past(rst) |-> resExp_q == tia_cfg_pkg::RES_RST) // see [R11]
    else $error("resolution not finest after reset");
  AST_RANGE: assert property ( // see [R12]
    resExp_q == $past(resExp_q) + 4'h1 |-> rangeNs == $past(rangeNs) << 1)
    else $error("range not doubled");
  AST_SEQ_STORE: assert property (accept && !clr // see [R13]
    |=> mCnt_q == $past(mCnt_q) + (SA+1)'(1) && seqMem[$past(mCnt_q[SA-1:0])] == $past(quant))
    else $error("measurement not stored in order");

  COV_INH_BLOCK: cover property (measStrobe && blocking);
  COV_LOG_FULL: cover property (iCnt_q == (IA+1)'(INH_DEPTH));
  COV_COARSE: cover property (accept && resExp_q == tia_cfg_pkg::RES_MAX);
endmodule
`default_nettype wire

/* File: rtl/tia_cfg_pkg.sv */
// Functional notes
// [R1] Enabled inhibit gates acquisition from the external input; disabled, input is ignored.
// [R2] Inhibit enable reads back 0 or 1; off after reset.
// [R3] Position of every inhibit activation in the acquired data is logged for readback; the log keeps only the first INH_DEPTH.
// [R4] Active sense picks which level inhibits; low after reset.
// [R5] Timing reference comes from internal, front-panel or backplane source.
// [R6] Measurement timing follows the selected reference; internal after reset.
// [R7] Lock is reached on an external reference within tolerance of nominal.
// [R8] Lock status reports lock of the currently selected source.
// [R9] Host changes setup only on internal source or a locked external one.
// [R10] Resolution only in power-of-two steps between finest and coarsest value.
// [R11] Resolution resets to its finest step.
// [R12] Maximum interval stays proportional to resolution.
// [R13] Sequential measurements are stored in acquisition order.
// [R14] After a source change status reads unlocked until confirmed; internal always locked.
//
// Constants shared by the timebase and gating control block.
// Assumes a 125 MHz register clock and 10 MHz reference ticks.
package tia_cfg_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RES = 8'h04;
  localparam logic [7:0] OFF_RANGE = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MCNT = 8'h10;
  localparam logic [7:0] OFF_ICNT = 8'h14;
  localparam logic [7:0] OFF_INDEX = 8'h18;
  localparam logic [7:0] OFF_SEQ = 8'h1c;
  localparam logic [7:0] OFF_INH = 8'h20;
  localparam logic [7:0] OFF_ACQ = 8'h24;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_SENSE_BIT = 1;
  localparam int CTRL_SRC_LSB = 2;
  localparam int ACQ_CLR_BIT = 0;
  localparam logic EN_RST = 1'b0;
  localparam logic SENSE_RST = 1'b0;
  localparam logic [3:0] RES_RST = 4'h0;
  localparam logic [3:0] RES_MAX = 4'hd;
  localparam logic [31:0] RANGE_BASE_NS = 32'h0000_0c80;

  typedef enum logic [1:0] {
    SRC_INT = 2'h0,
    SRC_EXT = 2'h1,
    SRC_BACKPLANE = 2'h2
  } ref_src_t;
  localparam ref_src_t SRC_RST = SRC_INT;

  typedef enum logic [1:0] {
    LK_HUNT = 2'b01,
    LK_LOCKED = 2'b10
  } lock_st_t;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int REF_HZ = 10_000_000;
  localparam int LOCK_WIN_US = 1000;
  localparam int LOCK_WIN_CYC = CLK_HZ / 1_000_000 * LOCK_WIN_US;
  localparam int LOCK_PPM = 100;
  localparam int LOCK_GOOD = 2;

endpackage

/* File: rtl/ref_lock_monitor.sv */
// Frequency lock monitor for the selected timing reference.
// Assumes reference ticks are one-cycle pulses synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module ref_lock_monitor #(
  parameter int WIN_CYC = tia_cfg_pkg::LOCK_WIN_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [1:0] refSrc,
  input wire logic extTick,
  input wire logic bpTick,
  output logic locked
);
  // Expected ticks per window and tolerance, at least one tick
  localparam int EXP = (WIN_CYC * (tia_cfg_pkg::REF_HZ / 1000))
    / (tia_cfg_pkg::CLK_HZ / 1000);
  localparam int TOL_RAW = EXP * tia_cfg_pkg::LOCK_PPM / 1_000_000;
  localparam int TOL = (TOL_RAW < 1) ? 1 : TOL_RAW;

  logic [1:0] srcPrev_q;
  logic [31:0] winCnt_q;
  logic [31:0] tickCnt_q;
  logic [1:0] good_q;
  tia_cfg_pkg::lock_st_t state_q, state_d;
  logic chg, tick, winEnd, good;
  logic [31:0] total;

  // Tick of the source now selected; internal needs no check
  assign chg = refSrc != srcPrev_q;
  assign tick = (refSrc == tia_cfg_pkg::SRC_EXT) ? extTick :
    (refSrc == tia_cfg_pkg::SRC_BACKPLANE) ? bpTick : 1'b0; // see [R5]
  assign winEnd = winCnt_q == 32'(WIN_CYC - 1);
  assign total = tickCnt_q + {31'h0000_0000, tick};
  // Count must sit inside the tolerance band around nominal
  assign good = (total >= 32'(EXP - TOL)) && (total <= 32'(EXP + TOL)); // see [R7]

  // Source tracking
  always_ff @(posedge mclk) begin
    if (rst) srcPrev_q <= tia_cfg_pkg::SRC_RST;
    else srcPrev_q <= refSrc;
  end

  // Measuring window, restarted on any source change
  always_ff @(posedge mclk) begin
    if (rst || chg || winEnd) begin
      winCnt_q <= 32'h0000_0000;
      tickCnt_q <= 32'h0000_0000;
    end else begin
      winCnt_q <= winCnt_q + 32'h0000_0001;
      tickCnt_q <= total;
    end
  end

  // Lock needs two good windows in a row
  always_comb begin
    state_d = state_q;
    if (chg) state_d = tia_cfg_pkg::LK_HUNT; // see [R14]
    else if (winEnd && !good) state_d = tia_cfg_pkg::LK_HUNT;
    else if (winEnd && good_q == 2'(tia_cfg_pkg::LOCK_GOOD - 1)) state_d = tia_cfg_pkg::LK_LOCKED;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= tia_cfg_pkg::LK_HUNT;
      good_q <= 2'h0;
    end else begin
      state_q <= state_d;
      if (chg || (winEnd && !good)) good_q <= 2'h0;
      else if (winEnd && good_q != 2'h3) good_q <= good_q + 2'h1;
    end
  end

  // Internal oscillator is always locked; others only once confirmed
  always_ff @(posedge mclk) begin
    if (rst) locked <= 1'b1;
    else locked <= (refSrc == tia_cfg_pkg::SRC_INT) ||
      (state_d == tia_cfg_pkg::LK_LOCKED); // see [R8] see [R14]
  end

  AST_LOCK_CHG: assert property (@(posedge mclk) disable iff (rst) // see [R14]
    chg && refSrc != tia_cfg_pkg::SRC_INT |=> !locked)
    else $error("lock kept after change");
  AST_INT_LOCK: assert property (@(posedge mclk) disable iff (rst) // see [R8]
    refSrc == tia_cfg_pkg::SRC_INT |=> locked)
    else $error("internal not locked");
  COV_EXT_LOCK: cover property (@(posedge mclk) disable iff (rst)
    refSrc != tia_cfg_pkg::SRC_INT ##1 $rose(locked));
endmodule
`default_nettype wire

/* File: test/ref_tick_model.sv */
// Reference tick source standing in for the front-panel or backplane reference.
// Assumes mclk at 125 MHz; ticks are one-cycle pulses synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
module ref_tick_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic offFreq,
  output logic tick
);
  // ----------------------------------------
  // Tick spacing
  // ----------------------------------------
  logic [4:0] cnt_q;
  logic phase_q;
  logic [4:0] gap;
  // Gaps of 12 and 13 cycles in turn average 12.5, exactly 10 MHz at 125 MHz;
  // offFreq uses 10-cycle gaps, far outside any lock tolerance
  assign gap = offFreq ? 5'h09 : (phase_q ? 5'h0c : 5'h0b);
  // A stopped reference stays low, like an unplugged input
  always_ff @(posedge mclk) begin
    if (rst || !run) begin
      cnt_q <= 5'h00;
      phase_q <= 1'b0;
      tick <= 1'b0;
    end else if (cnt_q == gap) begin
      cnt_q <= 5'h00;
      phase_q <= !phase_q;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: test/test_timebase_gating_ctrl.sv */
// Self-checking bench for the timebase and gating control block.
// Assumes the APB walk of one wait state and a shortened lock window.
`timescale 1ns/10ps
`default_nettype none
module test_timebase_gating_ctrl;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, inhibitIn = 1'b0, extRefTick, bpRefTick, measStrobe = 1'b0;
  logic [28:0] measTicks = 29'h0;
  logic acqBlocked, refLocked, extRun = 1'b0, bpRun = 1'b0, bpOff = 1'b0;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [31:0] seqExp[$], inhExp[$];
  logic [15:0] lfsr = 16'ha139;
  int n_fail = 0, n_compared = 0, res = 0, i;

  // ----------------------------------------
  // Clock, design and reference sources
  // ----------------------------------------
  always #4 mclk = !mclk;
  timebase_gating_ctrl #(.WIN_CYC(2500)) i_dut (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inhibitIn(inhibitIn), .extRefTick(extRefTick),
    .bpRefTick(bpRefTick), .measStrobe(measStrobe), .measTicks(measTicks),
    .acqBlocked(acqBlocked), .refLocked(refLocked));
  ref_tick_model i_ext (.mclk(mclk), .rst(rst), .run(extRun), .offFreq(1'b0),
    .tick(extRefTick));
  ref_tick_model i_bp (.mclk(mclk), .rst(rst), .run(bpRun), .offFreq(bpOff), .tick(bpRefTick));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  // Saturation mirrors the 16-bit store width
  function automatic logic [31:0] scaled(input logic [28:0] t, input int n);
    logic [28:0] s;
    s = t >> n;
    return (s > 29'h000ffff) ? 32'h0000_ffff : {3'h0, s};
  endfunction
  // One APB transfer; the expected answer is noted before the access phase
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err, input logic [31:0] exp);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    notes.push_back({!wr, err, exp});
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err = 1'b0);
    apb(1'b1, a, d, err, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
    apb(1'b0, a, 32'h0, err, exp);
  endtask
  // One offered measurement, noted when it ought to be stored
  task automatic meas(input logic [28:0] t, input logic take);
    @(posedge mclk);
    measStrobe <= 1'b1;
    measTicks <= t;
    if (take) seqExp.push_back(scaled(t, res));
    @(posedge mclk);
    measStrobe <= 1'b0;
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask

  // ----------------------------------------
  // Response watcher: oldest note against each answer
  // ----------------------------------------
  always @(posedge mclk) begin
    if (psel && penable && pready) begin
      note = notes.pop_front();
      check({31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check(prdata, note[31:0]);
    end
  end

  // ----------------------------------------
  // Watchdog, sized well past the lock waits
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin : main
    logic [15:0] r1, r2;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    rd(tia_cfg_pkg::OFF_CTRL, 32'h0);
    rd(tia_cfg_pkg::OFF_RES, 32'h0);
    rd(tia_cfg_pkg::OFF_RANGE, tia_cfg_pkg::RANGE_BASE_NS);
    rd(tia_cfg_pkg::OFF_STAT, 32'h1);
    rd(8'h28, 32'h0, 1'b1);
    for (i = 0; i <= 13; i++) begin
      wr(tia_cfg_pkg::OFF_RES, 32'(i));
      rd(tia_cfg_pkg::OFF_RANGE, tia_cfg_pkg::RANGE_BASE_NS << i);
    end
    wr(tia_cfg_pkg::OFF_RES, 32'he, 1'b1);
    rd(tia_cfg_pkg::OFF_RES, 32'hd);
    wr(tia_cfg_pkg::OFF_RES, 32'h2);
    res = 2;
    // Gating disabled: a wandering gating input must not block anything
    for (i = 0; i < 6; i++) begin
      r1 = rnd();
      r2 = rnd();
      inhibitIn <= r1[0];
      meas({r1[12:0], r2}, 1'b1);
    end
    meas(29'h1fff_ffff, 1'b1);
    inhibitIn <= 1'b1;
    wr(tia_cfg_pkg::OFF_CTRL, 32'h1);
    rd(tia_cfg_pkg::OFF_CTRL, 32'h1);
    meas(29'h0000_1234, 1'b1);
    inhibitIn <= 1'b0;
    inhExp.push_back(32'(seqExp.size()));
    settle();
    check({31'h0, acqBlocked}, 32'h1);
    rd(tia_cfg_pkg::OFF_STAT, 32'h3);
    meas(29'h0000_0777, 1'b0);
    inhibitIn <= 1'b1;
    settle();
    meas(29'h0000_0abc, 1'b1);
    wr(tia_cfg_pkg::OFF_CTRL, 32'h3);
    inhExp.push_back(32'(seqExp.size()));
    settle();
    meas(29'h0000_0555, 1'b0);
    wr(tia_cfg_pkg::OFF_CTRL, 32'h0);
    settle();
    meas(29'h0000_0999, 1'b1);
    rd(tia_cfg_pkg::OFF_MCNT, 32'(seqExp.size()));
    rd(tia_cfg_pkg::OFF_ICNT, 32'h2);
    for (i = 0; i < 2; i++) begin
      wr(tia_cfg_pkg::OFF_INDEX, 32'(i));
      rd(tia_cfg_pkg::OFF_INH, inhExp[i]);
    end
    for (i = 0; i < seqExp.size(); i++) begin
      wr(tia_cfg_pkg::OFF_INDEX, 32'(i));
      rd(tia_cfg_pkg::OFF_SEQ, seqExp[i]);
    end
    wr(tia_cfg_pkg::OFF_ACQ, 32'h1);
    rd(tia_cfg_pkg::OFF_MCNT, 32'h0);
    rd(tia_cfg_pkg::OFF_ICNT, 32'h0);
    // Index now lies past the emptied store, so the entry reads zero
    rd(tia_cfg_pkg::OFF_SEQ, 32'h0);
    seqExp.delete();
    // Front-panel reference: unlocked at once, locked within a few windows
    extRun <= 1'b1;
    wr(tia_cfg_pkg::OFF_CTRL, 32'h4);
    settle();
    check({31'h0, refLocked}, 32'h0);
    check({31'h0, acqBlocked}, 32'h1);
    meas(29'h0000_0100, 1'b0);
    for (i = 0; i < 10000 && refLocked !== 1'b1; i++) @(posedge mclk);
    check({31'h0, refLocked}, 32'h1);
    rd(tia_cfg_pkg::OFF_STAT, 32'h5);
    meas(29'h0000_0200, 1'b1);
    rd(tia_cfg_pkg::OFF_MCNT, 32'h1);
    // Backplane line running far off frequency never locks
    bpOff <= 1'b1;
    bpRun <= 1'b1;
    wr(tia_cfg_pkg::OFF_CTRL, 32'h8);
    repeat (8000) @(posedge mclk);
    check({31'h0, refLocked}, 32'h0);
    wr(tia_cfg_pkg::OFF_CTRL, 32'hc);
    rd(tia_cfg_pkg::OFF_STAT, 32'h8);
    // Backplane line brought to nominal locks after a stray window
    bpOff <= 1'b0;
    for (i = 0; i < 10000 && refLocked !== 1'b1; i++) @(posedge mclk);
    check({31'h0, refLocked}, 32'h1);
    rd(tia_cfg_pkg::OFF_STAT, 32'h9);
    wr(tia_cfg_pkg::OFF_CTRL, 32'h0);
    settle();
    check({31'h0, refLocked}, 32'h1);
    check({31'h0, acqBlocked}, 32'h0);
    // Reset in mid-run must bring back control, resolution, range, data count and status defaults from a changed state
    inhibitIn <= 1'b1;
    wr(tia_cfg_pkg::OFF_CTRL, 32'h3);
    wr(tia_cfg_pkg::OFF_RES, 32'h5);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(tia_cfg_pkg::OFF_CTRL, 32'h0);
    rd(tia_cfg_pkg::OFF_RES, 32'h0);
    rd(tia_cfg_pkg::OFF_RANGE, tia_cfg_pkg::RANGE_BASE_NS);
    rd(tia_cfg_pkg::OFF_MCNT, 32'h0);
    rd(tia_cfg_pkg::OFF_STAT, 32'h1);
    check({31'h0, acqBlocked}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
